//--- verilog/swdt_top.sv
// Function
// [RULE_01] Watchdog is enabled and counting after every chip reset.
// [RULE_02] Compatible mode: disable accepted only before end-of-initialization instruction.
// [RULE_03] Enhanced mode: disable and enable instructions act at any time.
// [RULE_04] Overflow raises internal hardware reset and pulls reset indication low.
// [RULE_05] Sixteen-bit counter advanced at system clock divided by 2, 4, 128, 256.
// [RULE_06] Software-set reload value sets the counter's upper byte.
// [RULE_07] Service loads reload value into upper byte and clears lower byte.
// [RULE_08] Default settings overflow after 3.28 ms at 40 MHz.
// [RULE_09] Interval spans about 13 us to 419 ms at 40 MHz.
// [RULE_10] Software services the watchdog before overflow to avoid reset.
// [RULE_11] Counts upward, overflow is all ones to zero, halted while disabled.
module swdt_top #(
  parameter int DEFAULT_CHECK_CYCLES = swdt_pkg::SWDT_DEFAULT_INTERVAL_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Instruction strobes from the core
  input wire logic service_instruction,
  input wire logic watchdog_disable_instruction,
  input wire logic watchdog_enable_instruction,
  input wire logic end_of_init_instruction,
  // Configuration
  input wire logic enhanced_mode,
  input wire logic [swdt_pkg::SWDT_SEL_W-1:0] prescale_sel,
  input wire logic [swdt_pkg::SWDT_BYTE_W-1:0] watchdog_reload_value,
  // Status and reset outputs
  output logic [swdt_pkg::SWDT_CNT_W-1:0] wdt_count,
  output logic wdt_enabled,
  output logic init_done,
  output logic hw_reset_req,
  output logic reset_indication_output_n
);
  import swdt_pkg::*;

  logic tick;
  logic [SWDT_PRE_W-1:0] terminal;
  logic accept_disable;
  logic overflow;

  // Divisor terminal from selection
  always_comb
  begin
    unique case (prescale_sel)
      SWDT_SEL_DIV2: terminal = SWDT_TERM_DIV2; // RULE_05
      SWDT_SEL_DIV4: terminal = SWDT_TERM_DIV4; // RULE_05
      SWDT_SEL_DIV128: terminal = SWDT_TERM_DIV128; // RULE_05
      SWDT_SEL_DIV256: terminal = SWDT_TERM_DIV256; // RULE_05
    endcase
  end

  swdt_prescaler #(
    .WIDTH(SWDT_PRE_W)
  ) i_swdt_prescaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(service_instruction || !wdt_enabled),
    .terminal(terminal),
    .tick(tick)
  );

  assign accept_disable = watchdog_disable_instruction && (enhanced_mode || !init_done); // RULE_02
  assign overflow = wdt_enabled && tick && (wdt_count == SWDT_CNT_MAX) && !service_instruction;

  // Initialization lock
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      init_done <= SWDT_INIT_DONE_RST;
    end
    else if (end_of_init_instruction)
    begin
      init_done <= 1'b1;
    end
  end

  // Enable state, enable wins over a same-cycle disable
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wdt_enabled <= SWDT_ENABLED_RST; // RULE_01
    end
    else if (watchdog_enable_instruction)
    begin
      wdt_enabled <= 1'b1; // RULE_03
    end
    else if (accept_disable)
    begin
      wdt_enabled <= 1'b0; // RULE_02 RULE_03
    end
  end

  // Watchdog counter
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wdt_count <= SWDT_CNT_RST; // RULE_01
    end
    else if (service_instruction)
    begin
      wdt_count <= {watchdog_reload_value, SWDT_LOW_CLEAR}; // RULE_06 RULE_07
    end
    else if (wdt_enabled && tick)
    begin
      wdt_count <= wdt_count + 1'b1; // RULE_05 RULE_08 RULE_09 RULE_11
    end
  end

  // Internal reset request pulse
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      hw_reset_req <= 1'b0;
    end
    else
    begin
      hw_reset_req <= overflow; // RULE_04
    end
  end

  // Reset indication: low in reset, released at end of init, low again on overflow
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      reset_indication_output_n <= SWDT_RSTIND_RST;
    end
    else if (overflow)
    begin
      reset_indication_output_n <= 1'b0; // RULE_04
    end
    else if (end_of_init_instruction && !hw_reset_req)
    begin
      reset_indication_output_n <= 1'b1;
    end
  end

  // Check helpers: cycles since service and stable settings
  logic [24:0] chk_cycles;
  logic chk_stable;
  logic [8:0] chk_gap;
  logic chk_sel_hold;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || service_instruction)
    begin
      chk_cycles <= '0;
    end
    else if (chk_cycles != '1)
    begin
      chk_cycles <= chk_cycles + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      chk_stable <= 1'b0;
    end
    else if (service_instruction)
    begin
      chk_stable <= 1'b1;
    end
    else if (!wdt_enabled || $changed(prescale_sel) || $changed(watchdog_reload_value))
    begin
      chk_stable <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || tick || !wdt_enabled || service_instruction)
    begin
      chk_gap <= '0;
    end
    else
    begin
      chk_gap <= chk_gap + 1'b1;
    end
  end

  // Divisor unchanged since the last reset, service or tick
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || service_instruction)
    begin
      chk_sel_hold <= 1'b1;
    end
    else if ($changed(prescale_sel))
    begin
      chk_sel_hold <= 1'b0;
    end
    else if (tick)
    begin
      chk_sel_hold <= 1'b1;
    end
  end

  AST_START_ENABLED: assert property (@(posedge clk_sys) // RULE_01
    !rst_n |=> wdt_enabled && wdt_count == SWDT_CNT_RST && !hw_reset_req)
    else $error("watchdog not enabled and cleared after reset");

  AST_COMPAT_LOCK: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    !enhanced_mode && init_done && wdt_enabled |=> wdt_enabled)
    else $error("watchdog disabled after init lock in compatible mode");

  AST_ENH_TOGGLE: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_03
    enhanced_mode && watchdog_disable_instruction && !watchdog_enable_instruction
    |=> !wdt_enabled ##1 (wdt_enabled == $past(watchdog_enable_instruction)))
    else $error("enhanced mode disable not honoured");

  AST_OVF_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
    wdt_enabled && tick && wdt_count == SWDT_CNT_MAX && !service_instruction
    |=> hw_reset_req && !reset_indication_output_n && wdt_count == SWDT_CNT_RST
    ##1 !hw_reset_req)
    else $error("overflow did not raise reset");

  AST_TICK_GAP: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    tick && chk_sel_hold
    |-> chk_gap == {1'b0, $past(terminal)} || chk_gap == {1'b0, $past(terminal)} + 9'h001)
    else $error("prescaler gap mismatch");

  AST_INCREMENT: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    wdt_enabled && tick && !service_instruction && wdt_count != SWDT_CNT_MAX
    |=> wdt_count == $past(wdt_count) + 16'h0001)
    else $error("counter did not advance by one");

  AST_SERVICE: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
    service_instruction |=> wdt_count == {$past(watchdog_reload_value), SWDT_LOW_CLEAR}
    && !hw_reset_req)
    else $error("service did not reload counter");

  AST_DEFAULT_INTERVAL: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
    hw_reset_req && chk_stable && prescale_sel == SWDT_SEL_DIV2
    && watchdog_reload_value == SWDT_LOW_CLEAR
    |-> chk_cycles inside {[DEFAULT_CHECK_CYCLES - SWDT_INTERVAL_TOLERANCE:
    DEFAULT_CHECK_CYCLES]})
    else $error("default interval out of range");

  AST_MIN_INTERVAL: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_09
    service_instruction && watchdog_reload_value == 8'hFF && prescale_sel == SWDT_SEL_DIV2
    |=> !hw_reset_req [*8])
    else $error("interval shorter than minimum");

  AST_MIN_SPAN: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_09
    hw_reset_req && chk_stable && prescale_sel == SWDT_SEL_DIV2
    && watchdog_reload_value == 8'hFF
    |-> chk_cycles >= 25'((int'(SWDT_TERM_DIV2) + 1) << SWDT_BYTE_W))
    else $error("minimum interval ended too early");

  AST_DISABLED_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    !wdt_enabled && !service_instruction |=> $stable(wdt_count) && !hw_reset_req)
    else $error("counter moved while disabled");

  COV_OVERFLOW: cover property (@(posedge clk_sys) disable iff (!rst_n) hw_reset_req);
  COV_SERVICE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    service_instruction && wdt_enabled);
  COV_ENH_DISABLE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    enhanced_mode && init_done && watchdog_disable_instruction ##1 !wdt_enabled);
  COV_COMPAT_REFUSE: cover property (@(posedge clk_sys) disable iff (!rst_n)
    !enhanced_mode && init_done && watchdog_disable_instruction ##1 wdt_enabled);

endmodule // swdt_top

//--- verilog/swdt_pkg.sv
// Shared constants of the system watchdog timer
package swdt_pkg;

  // Counter layout
  localparam int SWDT_CNT_W = 16;
  localparam int SWDT_BYTE_W = 8;
  localparam logic [15:0] SWDT_CNT_RST = 16'h0000;
  localparam logic [15:0] SWDT_CNT_MAX = 16'hFFFF;
  localparam logic [7:0] SWDT_LOW_CLEAR = 8'h00;

  // Prescaler selection codes and their divisors
  localparam int SWDT_SEL_W = 2;
  localparam logic [1:0] SWDT_SEL_DIV2 = 2'h0;
  localparam logic [1:0] SWDT_SEL_DIV4 = 2'h1;
  localparam logic [1:0] SWDT_SEL_DIV128 = 2'h2;
  localparam logic [1:0] SWDT_SEL_DIV256 = 2'h3;
  localparam int SWDT_PRE_W = 8;
  localparam logic [7:0] SWDT_TERM_DIV2 = 8'h01;
  localparam logic [7:0] SWDT_TERM_DIV4 = 8'h03;
  localparam logic [7:0] SWDT_TERM_DIV128 = 8'h7F;
  localparam logic [7:0] SWDT_TERM_DIV256 = 8'hFF;

  // Reset values of the control state
  localparam logic SWDT_ENABLED_RST = 1'b1;
  localparam logic SWDT_INIT_DONE_RST = 1'b0;
  localparam logic SWDT_RSTIND_RST = 1'b0;

  // Timing at the system clock rate
  localparam int SWDT_CLK_FREQ_MHZ = 40;
  localparam int SWDT_DEFAULT_INTERVAL_NS = 3_280_000;
  localparam int SWDT_DEFAULT_INTERVAL_CYCLES =
    SWDT_DEFAULT_INTERVAL_NS * SWDT_CLK_FREQ_MHZ / 1000;
  localparam int SWDT_INTERVAL_TOLERANCE = 256;

endpackage // swdt_pkg

//--- verilog/swdt_prescaler.sv
// Prescaler that turns the system clock into counter increments
module swdt_prescaler #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [WIDTH-1:0] terminal,
  // Increment strobe
  output logic tick
);

  logic [WIDTH-1:0] div_cnt;

  // Divider count, restarted on clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || clear)
    begin
      div_cnt <= '0;
    end
    else if (div_cnt == terminal)
    begin
      div_cnt <= '0;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // One pulse per terminal count
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || clear)
    begin
      tick <= 1'b0;
    end
    else
    begin
      tick <= (div_cnt == terminal);
    end
  end

endmodule // swdt_prescaler

//--- tb/swdt_top_bench.sv
// Self-checking bench of the system watchdog timer
module swdt_top_bench import swdt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int k; logic [15:0] e; logic [15:0] b;} swdt_note_s;
  logic clk_sys, rst_n, srv, dis, ena, eoi, enh;
  logic [1:0] sel;
  logic [7:0] rel;
  logic [15:0] cnt, base;
  logic wen, idn, hrq, rio_n;
  int n_errors, comparisons, t;
  int dv[4] = '{2, 4, 128, 256};
  logic [31:0] seed = 32'hF5BAED3D;
  swdt_note_s q[$];

  swdt_top i_swdt_top (.clk_sys(clk_sys), .rst_n(rst_n), .service_instruction(srv),
    .watchdog_disable_instruction(dis), .watchdog_enable_instruction(ena),
    .end_of_init_instruction(eoi), .enhanced_mode(enh), .prescale_sel(sel),
    .watchdog_reload_value(rel), .wdt_count(cnt), .wdt_enabled(wen), .init_done(idn),
    .hw_reset_req(hrq), .reset_indication_output_n(rio_n));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Note of a result expected after the coming rising edge
  task automatic note(int k, logic [15:0] e, logic [15:0] b = 16'h0000);
    q.push_back('{k, e, b});
  endtask

  // Monitor takes each note off the queue once the edge has landed
  initial
  begin
    forever
    begin
      @(posedge clk_sys);
      #1;
      while (q.size() > 0)
      begin
        swdt_note_s n;
        n = q.pop_front();
        case (n.k)
          0: check(cnt, n.e);
          1: check({15'h0, wen}, n.e);
          2: check({15'h0, idn}, n.e);
          3: check({15'h0, rio_n}, n.e);
          4: check({15'h0, hrq}, n.e);
          5: check(cnt - n.b, n.e);
          default: check({15'h0, (n.b + 3 >= n.e) && (n.b <= n.e + 3)}, 16'h0001);
        endcase
      end
    end
  end

  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One-cycle strobe: 0 service, 1 disable, 2 enable, 3 end of init
  task automatic pulse(int w);
    {srv, dis, ena, eoi} = 4'h8 >> w;
    cyc(1);
    {srv, dis, ena, eoi} = 4'h0;
    cyc(1);
  endtask

  task automatic wait_ovf(int lim, output int n);
    n = 0;
    while (hrq !== 1'b1)
    begin
      cyc(1);
      n++;
      if (n > lim)
      begin
        n_errors++;
        $display("CHECK FAILED at %0t: no overflow", $time);
        stop_test();
      end
    end
  endtask

  initial
  begin
    {srv, dis, ena, eoi, enh} = 5'h00;
    sel = SWDT_SEL_DIV2;
    rel = 8'h00;
    rst_n = 1'b0;
    n_errors = 0;
    comparisons = 0;
    cyc(16);
    rst_n = 1'b1;
    note(1, 16'h0001);
    note(2, 16'h0000);
    note(0, 16'h0000);
    cyc(2);
    $display("Reset state test done");
    for (int i = 0; i < 4; i++)
    begin
      sel = 2'(i);
      rel = 8'(rnd()) & 8'h7F;
      note(0, {rel, SWDT_LOW_CLEAR});
      pulse(0);
      cyc(3);
      base = cnt;
      cyc(511);
      note(5, 16'(512 / dv[i]), base);
      cyc(1);
    end
    $display("Prescaler and reload test done");
    note(1, 16'h0000);
    pulse(1);
    base = cnt;
    cyc(40);
    note(5, 16'h0000, base);
    note(1, 16'h0001);
    pulse(2);
    note(2, 16'h0001);
    note(3, 16'h0001);
    pulse(3);
    note(1, 16'h0001);
    pulse(1);
    cyc(2);
    enh = 1'b1;
    note(1, 16'h0000);
    pulse(1);
    note(1, 16'h0001);
    pulse(2);
    $display("Disable policy test done");
    sel = SWDT_SEL_DIV2;
    rel = 8'hFF;
    pulse(0);
    wait_ovf(600, t);
    note(6, 16'h0200, 16'(t));
    note(4, 16'h0000);
    note(3, 16'h0000);
    note(0, 16'h0000);
    cyc(3);
    $display("Overflow test done");
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    note(1, 16'h0001);
    note(2, 16'h0000);
    note(0, 16'h0000);
    cyc(2);
    $display("Second reset test done");
    stop_test();
  end
endmodule // swdt_top_bench
